// ===== src/pioa_pkg.sv
// Constants, register map and state codes of the processor I/O port access unit.
// Assumes a single AHB-Lite master and one external I/O decode partner.
package pioa_pkg;
    // Register byte offsets.
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_PORT = 8'h04;
    localparam logic [7:0] OFF_ACC = 8'h08;
    localparam logic [7:0] OFF_SRC = 8'h0c;
    localparam logic [7:0] OFF_DST = 8'h10;
    localparam logic [7:0] OFF_CNT = 8'h14;
    localparam logic [7:0] OFF_STAT = 8'h18;
    localparam logic [7:0] OFF_PERM0 = 8'h1c;
    localparam logic [7:0] OFF_PERM1 = 8'h20;
    localparam logic [7:0] OFF_MADDR = 8'h24;
    localparam logic [7:0] OFF_BUF = 8'h40;
    // Control field positions.
    localparam int CTRL_START = 0;
    localparam int CTRL_IN = 1;
    localparam int CTRL_SIZE = 2;
    localparam int CTRL_STR = 4;
    localparam int CTRL_REP = 5;
    localparam int CTRL_DF = 6;
    localparam int CTRL_REGPORT = 7;
    localparam int CTRL_MEM = 8;
    localparam int CTRL_PCD = 9;
    localparam int CTRL_PROT = 10;
    localparam int CTRL_CPL = 11;
    localparam int CTRL_IO_PRIVILEGE_LEVEL = 13;
    // Status field positions.
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_GP = 2;
    localparam int STAT_PAR = 3;
    localparam int STAT_SPLIT = 4;
    // Reset values.
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [63:0] RST_PERM = 64'hffff_ffff_ffff_ffff;
    // Item size codes, the last port of the I/O space, the AHB-Lite NONSEQ transfer code and the state codes.
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [15:0] IO_SPACE_TOP = 16'hffff;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    typedef enum logic [4:0] {
        PIOA_IDLE = 5'b00001,
        PIOA_CHECK = 5'b00010,
        PIOA_REQ = 5'b00100,
        PIOA_REL = 5'b01000,
        PIOA_NEXT = 5'b10000
    } pioa_state_t;
endpackage : pioa_pkg

// ===== src/pioa_port_unit.sv
// Processor I/O port access unit: AHB-Lite registers, permission check and I/O bus cycles.
// Assumes an external decoder answering each request with a four-phase req/ack handshake.
//
// Notes on behaviour
// - Separate 64K byte-port space, 16-bit port addresses.
// - Memory/I/O select high for memory, low I/O.
// - Transfers of 8, 16 or 32 bits.
// - Aligned word or dword port takes one cycle.
// - Ports crossing a dword boundary split into a second bus cycle.
// - I/O write finishes before next operation starts.
// - Parity errors on I/O cycles are reported.
// - Inactive cache enable input blocks all caching.
// - Page cache disable flag blocks caching per access.
// - Single items move between port and accumulator.
// - Strings use port register and source/destination index.
// - Repeated strings step index by size per direction.
// - Port operations never produce memory cycles.
// - Re-executed memory-mapped access may repeat its effect.
// - Privilege above I/O level consults permission bitmap.
// - Every covered byte port bit is tested.
// - Ports past the bitmap are denied.
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ns
module pioa_port_unit #(
    parameter int PERM_PORTS = 64,
    parameter int BUF_BYTES = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] io_addr,
    output logic io_mem_sel,
    output logic [3:0] io_byte_en,
    output logic [31:0] io_wdata,
    output logic io_write,
    output logic io_req,
    output logic io_cacheable,
    input wire logic io_ack,
    input wire logic [31:0] io_rdata,
    input wire logic io_parity_err,
    input wire logic cache_enable_input_n
);
    localparam int BW = $clog2(BUF_BYTES);

    function automatic logic is_buf(input logic [7:0] a);
        is_buf = (a >= pioa_pkg::OFF_BUF) && (a < pioa_pkg::OFF_BUF + 8'(BUF_BYTES));
    endfunction : is_buf

    // Pins pass two flip-flops; only the second stage is read.
    logic [34:0] sync1_reg;
    logic [34:0] sync2_reg;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else
        begin
            sync1_reg <= {io_ack, io_parity_err, cache_enable_input_n, io_rdata};
            sync2_reg <= sync1_reg;
        end
    end
    logic ack_s;
    logic par_s;
    logic ken_n_s;
    logic [31:0] rdata_s;
    assign {ack_s, par_s, ken_n_s, rdata_s} = sync2_reg;

    // AHB-Lite address phase capture; the slave never waits and always says OKAY.
    logic ap_wr_reg, ap_wr_next;
    logic [7:0] ap_addr_reg, ap_addr_next;
    logic [31:0] hrdata_reg, hrdata_next;
    logic accept;
    logic [31:0] rd_word;
    assign accept = hsel && hready && (htrans == pioa_pkg::HTRANS_NONSEQ || htrans == 2'h3);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;

    always_comb
    begin
        ap_wr_next = accept && hwrite;
        ap_addr_next = accept ? haddr[7:0] : ap_addr_reg;
        hrdata_next = (accept && !hwrite) ? rd_word : hrdata_reg;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_wr_reg <= 1'b0;
            ap_addr_reg <= 8'h00;
            hrdata_reg <= pioa_pkg::RST_WORD;
        end
        else
        begin
            ap_wr_reg <= ap_wr_next;
            ap_addr_reg <= ap_addr_next;
            hrdata_reg <= hrdata_next;
        end
    end

    // Operation registers and state.
    pioa_pkg::pioa_state_t st_reg, st_next;
    logic [31:0] ctrl_reg, ctrl_next, port_reg, port_next, acc_reg, acc_next;
    logic [31:0] src_reg, src_next, dst_reg, dst_next, cnt_reg, cnt_next;
    logic [31:0] maddr_reg, maddr_next;
    logic [63:0] perm_reg, perm_next, rbuf_reg, rbuf_next;
    logic done_reg, done_next, gp_reg, gp_next, par_reg, par_next;
    logic split_reg, split_next, ph_reg, ph_next;
    logic [7:0] mem_reg [BUF_BYTES];
    logic [7:0] mem_next [BUF_BYTES];
    logic [31:0] addr_reg, addr_next, wdata_reg, wdata_next;
    logic [3:0] be_reg, be_next;
    logic write_reg, write_next, msel_reg, msel_next;
    logic req_reg, req_next, cache_reg, cache_next;

    logic busy, mem_op, str_op, gp_need, denied, need_split, wr_op;
    logic [15:0] port;
    logic [31:0] cur, nb, item_out, rd_item, idx, mask32;
    logic [3:0] mask;
    logic [7:0] be_full;
    logic [63:0] wd64;
    logic [16:0] pp;
    logic [7:0] wa;

    assign busy = (st_reg != pioa_pkg::PIOA_IDLE);
    assign mem_op = ctrl_reg[pioa_pkg::CTRL_MEM] && !ctrl_reg[pioa_pkg::CTRL_STR];
    assign str_op = ctrl_reg[pioa_pkg::CTRL_STR];
    assign wr_op = !ctrl_reg[pioa_pkg::CTRL_IN];
    // Strings always take the port register; single items may use the immediate half.
    assign port = (str_op || ctrl_reg[pioa_pkg::CTRL_REGPORT]) ? port_reg[15:0]
                                                               : port_reg[31:16];
    assign idx = wr_op ? src_reg : dst_reg;
    assign cur = mem_op ? maddr_reg : {16'h0000, port};
    assign mask = (ctrl_reg[3:2] == pioa_pkg::SZ_BYTE) ? 4'h1
                : (ctrl_reg[3:2] == pioa_pkg::SZ_WORD) ? 4'h3 : 4'hf;
    assign nb = (mask == 4'h1) ? 32'h1 : (mask == 4'h3) ? 32'h2 : 32'h4;
    assign mask32 = {{8{mask[3]}}, {8{mask[2]}}, {8{mask[1]}}, {8{mask[0]}}};
    assign be_full = 8'({4'h0, mask} << cur[1:0]);
    assign need_split = |be_full[7:4];
    assign gp_need = ctrl_reg[pioa_pkg::CTRL_PROT] && !mem_op
                     && (ctrl_reg[12:11] > ctrl_reg[14:13]);
    assign wd64 = 64'({32'h0, item_out} << {cur[1:0], 3'b000});
    assign rd_item = 32'(rbuf_reg >> {cur[1:0], 3'b000});
    assign wa = ap_addr_reg - pioa_pkg::OFF_BUF;

    always_comb
    begin
        item_out = acc_reg;
        denied = 1'b0;
        pp = 17'h0;
        for (int b = 0; b < 4; b++)
        begin
            if (str_op)
                item_out[8*b +: 8] = mem_reg[BW'(src_reg + 32'(b))];
            pp = {1'b0, port} + 17'(b);
            if (mask[b])
                denied = denied || (pp >= 17'(PERM_PORTS)) || perm_reg[6'(pp)];
        end
        case (haddr[7:0])
            pioa_pkg::OFF_CTRL: rd_word = ctrl_reg;
            pioa_pkg::OFF_PORT: rd_word = port_reg;
            pioa_pkg::OFF_ACC: rd_word = acc_reg;
            pioa_pkg::OFF_SRC: rd_word = src_reg;
            pioa_pkg::OFF_DST: rd_word = dst_reg;
            pioa_pkg::OFF_CNT: rd_word = cnt_reg;
            pioa_pkg::OFF_STAT: rd_word = {27'h0, split_reg, par_reg, gp_reg, done_reg, busy};
            pioa_pkg::OFF_PERM0: rd_word = perm_reg[31:0];
            pioa_pkg::OFF_PERM1: rd_word = perm_reg[63:32];
            pioa_pkg::OFF_MADDR: rd_word = maddr_reg;
            default: rd_word = is_buf(haddr[7:0]) ? {24'h0, mem_reg[BW'(haddr[7:0] - pioa_pkg::OFF_BUF)]}
                                                  : 32'h0;
        endcase
    end

    always_comb
    begin
        st_next = st_reg;
        {ctrl_next, port_next, acc_next, src_next, dst_next} = {ctrl_reg, port_reg, acc_reg, src_reg, dst_reg};
        {cnt_next, maddr_next, perm_next, rbuf_next} = {cnt_reg, maddr_reg, perm_reg, rbuf_reg};
        {done_next, gp_next, par_next, split_next, ph_next} = {done_reg, gp_reg, par_reg, split_reg, ph_reg};
        mem_next = mem_reg;
        {addr_next, wdata_next, be_next} = {addr_reg, wdata_reg, be_reg};
        {write_next, msel_next, req_next, cache_next} = {write_reg, msel_reg, req_reg, cache_reg};
        // Status bits clear on a one; an event in the same cycle sets them again below.
        if (ap_wr_reg && ap_addr_reg == pioa_pkg::OFF_STAT)
        begin
            done_next = done_reg && !hwdata[pioa_pkg::STAT_DONE];
            gp_next = gp_reg && !hwdata[pioa_pkg::STAT_GP];
            par_next = par_reg && !hwdata[pioa_pkg::STAT_PAR];
            split_next = split_reg && !hwdata[pioa_pkg::STAT_SPLIT];
        end
        // Operand registers are frozen while an operation runs, so a later operation
        // cannot start before the bus cycles of the current one have finished.
        if (ap_wr_reg && !busy)
        begin
            case (ap_addr_reg)
                pioa_pkg::OFF_CTRL:
                begin
                    ctrl_next = hwdata & ~32'h1;
                    if (hwdata[pioa_pkg::CTRL_START])
                    begin
                        st_next = pioa_pkg::PIOA_CHECK;
                        done_next = 1'b0;
                    end
                end
                pioa_pkg::OFF_PORT: port_next = hwdata;
                pioa_pkg::OFF_ACC: acc_next = hwdata;
                pioa_pkg::OFF_SRC: src_next = hwdata;
                pioa_pkg::OFF_DST: dst_next = hwdata;
                pioa_pkg::OFF_CNT: cnt_next = hwdata;
                pioa_pkg::OFF_PERM0: perm_next[31:0] = hwdata;
                pioa_pkg::OFF_PERM1: perm_next[63:32] = hwdata;
                pioa_pkg::OFF_MADDR: maddr_next = hwdata;
                default:
                    if (is_buf(ap_addr_reg))
                        mem_next[BW'(wa)] = hwdata[7:0];
            endcase
        end
        unique case (st_reg)
            pioa_pkg::PIOA_IDLE: ;
            pioa_pkg::PIOA_CHECK:
            begin
                if (str_op && ctrl_reg[pioa_pkg::CTRL_REP] && cnt_reg == 32'h0)
                begin
                    st_next = pioa_pkg::PIOA_IDLE;
                    done_next = 1'b1;
                end
                else if (gp_need && denied)
                begin
                    st_next = pioa_pkg::PIOA_IDLE;
                    gp_next = 1'b1;
                end
                else
                begin
                    addr_next = {cur[31:2], 2'b00};
                    be_next = be_full[3:0];
                    wdata_next = wd64[31:0];
                    write_next = wr_op;
                    msel_next = mem_op;
                    // Caching needs a memory cycle, the pin active and the page flag clear.
                    cache_next = mem_op && !ken_n_s && !ctrl_reg[pioa_pkg::CTRL_PCD];
                    req_next = 1'b1;
                    ph_next = 1'b0;
                    st_next = pioa_pkg::PIOA_REQ;
                end
            end
            pioa_pkg::PIOA_REQ:
                if (ack_s)
                begin
                    if (ph_reg)
                        rbuf_next[63:32] = rdata_s;
                    else
                        rbuf_next[31:0] = rdata_s;
                    par_next = par_next || par_s;
                    req_next = 1'b0;
                    st_next = pioa_pkg::PIOA_REL;
                end
            pioa_pkg::PIOA_REL:
                if (!ack_s)
                begin
                    if (!ph_reg && need_split)
                    begin
                        // The upper lanes follow in a second cycle at the next dword.
                        addr_next = addr_reg + 32'h4;
                        be_next = be_full[7:4];
                        wdata_next = wd64[63:32];
                        ph_next = 1'b1;
                        split_next = 1'b1;
                        req_next = 1'b1;
                        st_next = pioa_pkg::PIOA_REQ;
                    end
                    else
                        st_next = pioa_pkg::PIOA_NEXT;
                end
            pioa_pkg::PIOA_NEXT:
            begin
                if (!wr_op && str_op)
                    for (int b = 0; b < 4; b++)
                        if (mask[b])
                            mem_next[BW'(dst_reg + 32'(b))] = rd_item[8*b +: 8];
                if (!wr_op && !str_op)
                    acc_next = (acc_reg & ~mask32) | (rd_item & mask32);
                if (str_op && wr_op)
                    src_next = ctrl_reg[pioa_pkg::CTRL_DF] ? src_reg - nb : src_reg + nb;
                if (str_op && !wr_op)
                    dst_next = ctrl_reg[pioa_pkg::CTRL_DF] ? dst_reg - nb : dst_reg + nb;
                if (str_op && ctrl_reg[pioa_pkg::CTRL_REP] && cnt_reg != 32'h1)
                begin
                    cnt_next = cnt_reg - 32'h1;
                    st_next = pioa_pkg::PIOA_CHECK;
                end
                else
                begin
                    if (str_op && ctrl_reg[pioa_pkg::CTRL_REP])
                        cnt_next = 32'h0;
                    done_next = 1'b1;
                    st_next = pioa_pkg::PIOA_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_reg <= pioa_pkg::PIOA_IDLE;
            {ctrl_reg, port_reg, acc_reg, src_reg} <= {4{pioa_pkg::RST_WORD}};
            {dst_reg, cnt_reg, maddr_reg} <= {3{pioa_pkg::RST_WORD}};
            perm_reg <= pioa_pkg::RST_PERM;
            rbuf_reg <= {2{pioa_pkg::RST_WORD}};
            {done_reg, gp_reg, par_reg, split_reg, ph_reg} <= 5'h00;
            for (int i = 0; i < BUF_BYTES; i++)
                mem_reg[i] <= 8'h00;
            {addr_reg, wdata_reg} <= {2{pioa_pkg::RST_WORD}};
            be_reg <= 4'h0;
            {write_reg, msel_reg, req_reg, cache_reg} <= 4'h0;
        end
        else
        begin
            st_reg <= st_next;
            {ctrl_reg, port_reg, acc_reg, src_reg} <= {ctrl_next, port_next, acc_next, src_next};
            {dst_reg, cnt_reg, maddr_reg} <= {dst_next, cnt_next, maddr_next};
            perm_reg <= perm_next;
            rbuf_reg <= rbuf_next;
            {done_reg, gp_reg, par_reg, split_reg, ph_reg} <=
                {done_next, gp_next, par_next, split_next, ph_next};
            mem_reg <= mem_next;
            {addr_reg, wdata_reg} <= {addr_next, wdata_next};
            be_reg <= be_next;
            {write_reg, msel_reg, req_reg, cache_reg} <= {write_next, msel_next, req_next, cache_next};
        end
    end

    assign io_addr = addr_reg;
    assign io_mem_sel = msel_reg;
    assign io_byte_en = be_reg;
    assign io_wdata = wdata_reg;
    assign io_write = write_reg;
    assign io_req = req_reg;
    assign io_cacheable = cache_reg;

    io_space_a: assert property (@(posedge hclk) disable iff (!hresetn)
        io_req && !io_mem_sel |-> io_addr[31:16] == 16'h0)
        else $error("I/O cycle address above 16 bits");
    io_select_a: assert property (@(posedge hclk) disable iff (!hresetn)
        io_req && !mem_op |-> !io_mem_sel)
        else $error("Port operation drove a memory cycle");
    aligned_single_a: assert property (@(posedge hclk) disable iff (!hresetn)
        st_reg == pioa_pkg::PIOA_REL && !ack_s && !need_split |=> st_reg == pioa_pkg::PIOA_NEXT)
        else $error("Aligned access used a second cycle");
    split_upper_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(io_req) && ph_reg |-> io_addr == $past(io_addr) + 32'h4 && io_byte_en == be_full[7:4])
        else $error("Split cycle not at the next higher dword");
    write_first_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(done_reg) |-> !io_req && !ack_s)
        else $error("Done raised before the bus cycle closed");
    gp_nobus_a: assert property (@(posedge hclk) disable iff (!hresetn)
        st_reg == pioa_pkg::PIOA_CHECK && gp_need && denied
        && !(str_op && ctrl_reg[pioa_pkg::CTRL_REP] && cnt_reg == 32'h0)
        |=> gp_reg && !io_req ##1 !io_req)
        else $error("Denied access reached the bus");
    map_beyond_a: assert property (@(posedge hclk) disable iff (!hresetn)
        st_reg == pioa_pkg::PIOA_CHECK && gp_need && port >= 16'(PERM_PORTS)
        && !(str_op && ctrl_reg[pioa_pkg::CTRL_REP] && cnt_reg == 32'h0) |=> gp_reg)
        else $error("Port beyond bitmap was allowed");
    parity_seen_a: assert property (@(posedge hclk) disable iff (!hresetn)
        st_reg == pioa_pkg::PIOA_REQ && ack_s && par_s |=> par_reg)
        else $error("Parity error on a cycle was lost");
    cache_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
        io_req && io_cacheable |-> io_mem_sel && !ctrl_reg[pioa_pkg::CTRL_PCD])
        else $error("Cacheable cycle despite blocking");
    index_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
        st_reg == pioa_pkg::PIOA_NEXT && str_op && wr_op && !ctrl_reg[pioa_pkg::CTRL_DF]
        |=> src_reg == $past(src_reg) + $past(nb))
        else $error("Source index did not advance by item size");
endmodule : pioa_port_unit

// ===== tb/pioa_io_model.sv
// Behavioural I/O decoder and peripheral partner for the port access unit.
// Assumes the unit's four-phase req/ack link with outputs held while io_req is high.
`timescale 1ns/1ns
module pioa_io_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic io_req,
    input wire logic [31:0] io_addr,
    input wire logic [3:0] io_byte_en,
    input wire logic [31:0] io_wdata,
    input wire logic io_write,
    input wire logic io_mem_sel,
    input wire logic io_cacheable,
    input wire logic [1:0] wait_cycles,
    input wire logic perr_on,
    output logic io_ack,
    output logic [31:0] io_rdata,
    output logic io_parity_err
);
    int cnt;
    int waited;
    logic [31:0] log_a [8];
    logic [3:0] log_be [8];
    logic [31:0] log_wd [8];
    logic [2:0] log_f [8];
    // Each byte lane answers with the low byte of its port number xor 5a.
    function automatic logic [31:0] lanes(logic [31:0] a);
        for (int k = 0; k < 4; k++)
            lanes[8*k +: 8] = (a[7:0] + 8'(k)) ^ 8'h5a;
    endfunction : lanes
    // Every cycle is logged with its select line so the bench can tell ports from memory.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            io_ack <= 1'b0;
            io_rdata <= 32'h0;
            io_parity_err <= 1'b0;
            cnt <= 0;
            waited <= 0;
        end
        else if (io_req && !io_ack)
        begin
            waited <= waited + 1;
            if (waited >= int'(wait_cycles))
            begin
                io_ack <= 1'b1;
                io_rdata <= lanes(io_addr);
                io_parity_err <= perr_on;
                log_a[cnt % 8] <= io_addr;
                log_be[cnt % 8] <= io_byte_en;
                log_wd[cnt % 8] <= io_wdata;
                log_f[cnt % 8] <= {io_write, io_mem_sel, io_cacheable};
                cnt <= cnt + 1;
                waited <= 0;
            end
        end
        else if (!io_req && io_ack)
        begin
            // Released data lines show the inverse so a stale sample cannot pass.
            io_ack <= 1'b0;
            io_rdata <= ~io_rdata;
            io_parity_err <= 1'b0;
        end
    end
endmodule : pioa_io_model

// ===== tb/tb_processor_io_port_access.sv
// Self-checking bench of the port access unit over AHB-Lite with a decoder model.
// Assumes hreadyout is the bus hready and the partner answers after 0 to 3 cycles.
`timescale 1ns/1ns
module tb_processor_io_port_access;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, io_addr, io_wdata, io_rdata;
    logic [1:0] htrans = 2'h0, wait_cycles = 2'h0;
    logic [3:0] io_byte_en;
    logic io_mem_sel, io_write, io_req, io_cacheable, io_ack, io_parity_err;
    logic perr_on = 1'b0, cache_n = 1'b0;
    logic [31:0] seed = 32'h3038, a, r, s;
    logic [7:0] bb [16];
    int n, miscompares = 0, checks_done = 0, cycles = 0;
    int t_port [7] = '{8, 8, 8, 10, 62, 63, 64};
    logic [31:0] t_perm [7] = '{32'hffffffff, 32'hffffffff, 32'hfffff0ff, 32'hfffff0ff, 0, 0, 0};
    logic [1:0] t_sz [7] = '{2, 2, 2, 2, 1, 1, 0};
    logic [1:0] t_io_privilege_level [7] = '{3, 0, 0, 0, 0, 0, 0};
    logic [6:0] t_gp = 7'b1101010;
    pioa_port_unit pioa_port_unit_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .io_addr(io_addr), .io_mem_sel(io_mem_sel), .io_byte_en(io_byte_en),
        .io_wdata(io_wdata), .io_write(io_write), .io_req(io_req),
        .io_cacheable(io_cacheable), .io_ack(io_ack), .io_rdata(io_rdata),
        .io_parity_err(io_parity_err), .cache_enable_input_n(cache_n));
    pioa_io_model model_inst (.hclk(hclk), .hresetn(hresetn), .io_req(io_req),
        .io_addr(io_addr), .io_byte_en(io_byte_en), .io_wdata(io_wdata),
        .io_write(io_write), .io_mem_sel(io_mem_sel), .io_cacheable(io_cacheable),
        .wait_cycles(wait_cycles), .perr_on(perr_on), .io_ack(io_ack),
        .io_rdata(io_rdata), .io_parity_err(io_parity_err));
    initial
    begin
        forever #20 hclk = ~hclk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [31:0] ctl(logic [1:0] sz, logic [31:0] f);
        return 32'h81 | (32'(sz) << pioa_pkg::CTRL_SIZE) | f;
    endfunction : ctl
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= pioa_pkg::HTRANS_NONSEQ;
        haddr <= {24'h0, ad};
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, ad, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] ad, output logic [31:0] q);
        bus(1'b0, ad, 32'h0, q);
    endtask : rd
    // Starts one operation and returns its status once busy has cleared.
    task automatic run(input logic [31:0] c, output logic [31:0] st);
        logic [31:0] w;
        w = rnd();
        wait_cycles <= w[1:0];
        n = model_inst.cnt;
        wr(pioa_pkg::OFF_CTRL, c);
        do rd(pioa_pkg::OFF_STAT, st); while (st[pioa_pkg::STAT_BUSY] !== 1'b0);
        wr(pioa_pkg::OFF_STAT, 32'h1e);
    endtask : run
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            final_report();
        end
    end
    initial
    begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rd(pioa_pkg::OFF_CTRL, r);
        chk(r, pioa_pkg::RST_WORD);
        chk(hresp, 1'b0);
        rd(pioa_pkg::OFF_PERM1, r);
        chk(r, pioa_pkg::RST_PERM[63:32]);
        wr(8'h30, rnd());
        rd(8'h30, r);
        chk(r, 32'h0);
        $display("test reset done");
        // Two ordered accesses instead of one wide one: dword out, then word in.
        a = rnd();
        wr(pioa_pkg::OFF_ACC, a);
        wr(pioa_pkg::OFF_PORT, 32'h4);
        run(ctl(2'h2, 32'h0), s);
        chk(model_inst.cnt - n, 1);
        chk(io_req, 1'b0);
        chk(model_inst.log_a[n % 8], 32'h4);
        chk(model_inst.log_be[n % 8], 4'hf);
        chk(model_inst.log_wd[n % 8], a);
        chk(model_inst.log_f[n % 8][2:1], 2'b10);
        wr(pioa_pkg::OFF_PORT, 32'h3);
        run(ctl(2'h1, 32'h2), s);
        chk(s[pioa_pkg::STAT_SPLIT], 1'b1);
        chk(model_inst.cnt - n, 2);
        chk({model_inst.log_a[n % 8], model_inst.log_be[n % 8]}, {32'h0, 4'h8});
        chk({model_inst.log_a[(n + 1) % 8], model_inst.log_be[(n + 1) % 8]}, 36'h41);
        rd(pioa_pkg::OFF_ACC, r);
        chk(r, {a[31:16], 8'h04 ^ 8'h5a, 8'h03 ^ 8'h5a});
        $display("test single done");
        wr(pioa_pkg::OFF_PERM1, 32'h0);
        for (int i = 0; i < 7; i++)
        begin
            wr(pioa_pkg::OFF_PERM0, t_perm[i]);
            wr(pioa_pkg::OFF_PORT, 32'(t_port[i]));
            run(ctl(t_sz[i], 32'h1c00 | (32'(t_io_privilege_level[i]) << pioa_pkg::CTRL_IO_PRIVILEGE_LEVEL)), s);
            chk({s[pioa_pkg::STAT_GP], 32'(model_inst.cnt - n)}, {t_gp[i], 32'(!t_gp[i])});
        end
        perr_on <= 1'b1;
        // Port taken from the immediate half this time.
        wr(pioa_pkg::OFF_PORT, 32'h0024_003f);
        run(ctl(2'h0, 32'h2) ^ 32'h80, s);
        chk(s[pioa_pkg::STAT_PAR], 1'b1);
        chk(model_inst.log_a[n % 8], 32'h24);
        perr_on <= 1'b0;
        $display("test protect done");
        for (int k = 0; k < 4; k++)
        begin
            // Memory-mapped ranges are made uncacheable by holding the enable inactive (k 1) or setting the page flag (k 2).
            cache_n <= (k == 1);
            repeat (3) @(posedge hclk);
            a = {rnd() & 32'hfffffffc};
            wr(pioa_pkg::OFF_MADDR, a);
            run(ctl(2'h2, 32'h100 | ((k == 2) ? 32'h200 : 32'h0)), s);
            chk(model_inst.cnt - n, 1);
            chk(model_inst.log_a[n % 8], a);
            chk(model_inst.log_f[n % 8], {2'b11, k == 0 || k == 3});
        end
        $display("test memory done");
        for (int k = 0; k < 16; k++)
        begin
            bb[k] = rnd();
            wr(pioa_pkg::OFF_BUF + 8'(k), {24'h0, bb[k]});
        end
        wr(pioa_pkg::OFF_PORT, 32'h10);
        wr(pioa_pkg::OFF_SRC, 32'h2);
        wr(pioa_pkg::OFF_CNT, 32'h3);
        run(ctl(2'h0, 32'h30), s);
        chk(model_inst.cnt - n, 3);
        chk(model_inst.log_wd[(n + 2) % 8][7:0], bb[4]);
        rd(pioa_pkg::OFF_SRC, r);
        chk(r, 32'h5);
        wr(pioa_pkg::OFF_DST, 32'h9);
        wr(pioa_pkg::OFF_CNT, 32'h2);
        run(ctl(2'h0, 32'h72), s);
        rd(pioa_pkg::OFF_DST, r);
        chk(r, 32'h7);
        rd(pioa_pkg::OFF_BUF + 8'h8, r);
        chk(r, {24'h0, 8'h10 ^ 8'h5a});
        $display("test string done");
        final_report();
    end
endmodule : tb_processor_io_port_access
